/* File: fspc_ctrl.sv */
// Notes on behaviour
// - Block erase leaves every byte FFH.
// - Halt ends within 10 us plus 2 clocks.
// - Protect error flag readable as one bit.
// - Pins hold halt state in self programming.
// - Security settings ignored in self programming.
// - Protect byte refuses write and erase.
// - No interrupt service in self programming.
// - CPU stalls while a command runs.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_cfg.svh"

module fspc_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        cpu_halt,
  output var  logic        cpu_stall,
  output var  logic        int_block,
  output var  logic        pin_hold
);
  import fspc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic          mode_r, unlock_r, proterr_r, refused_r, fail_r;
  logic          halt_arm_r, halting_r;
  logic [11:0]   halt_cnt_r;
  logic [7:0]    aph_r, apl_r, ach_r, acl_r, wdat_r, protb_r;
  fspc_cmd_t     cmd_r;
  fspc_state_t   state_r;
  logic [7:0]    ptr_r;
  fspc_mem_req_t mreq;
  logic [7:0]    mrd;
  logic          wr_en, rd_en, cmd_start, busy;
  logic [31:0]   rd_val;
  logic [8:0]    status_val;

  // Decode used for the error response and write strobes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `FSPC_OFF_MODE) | hit(a, `FSPC_OFF_PROTCMD) | hit(a, `FSPC_OFF_STATUS)
           | hit(a, `FSPC_OFF_CMD) | hit(a, `FSPC_OFF_APH) | hit(a, `FSPC_OFF_APL)
           | hit(a, `FSPC_OFF_ACH) | hit(a, `FSPC_OFF_ACL) | hit(a, `FSPC_OFF_WDATA)
           | hit(a, `FSPC_OFF_PROTBYTE);
  endfunction : mapped

  // ----------------------------------------------------------------
  // APB slave: one wait state, access completes when pready is high
  // ----------------------------------------------------------------
  assign wr_en = psel & penable & pready & pwrite & mapped(paddr);
  assign rd_en = psel & penable & ~pready & ~pwrite;
  assign busy  = (state_r != FSPC_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
    end
  end

  // Status word; protect error alone in bit 0 for single-bit tests
  always_comb begin
    status_val = '0;
    status_val[`FSPC_ST_PROTERR] = proterr_r;
    status_val[`FSPC_ST_BUSY]    = busy;
    status_val[`FSPC_ST_REFUSED] = refused_r;
    status_val[`FSPC_ST_FAIL]    = fail_r;
    status_val[`FSPC_ST_MODE]    = mode_r;
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rd_val = '0;
    unique case (paddr)
      `FSPC_OFF_MODE:     rd_val = {31'h0, mode_r};
      `FSPC_OFF_STATUS:   rd_val = {23'h0, status_val};
      `FSPC_OFF_CMD:      rd_val = {29'h0, cmd_r};
      `FSPC_OFF_APH:      rd_val = {24'h0, aph_r};
      `FSPC_OFF_APL:      rd_val = {24'h0, apl_r};
      `FSPC_OFF_ACH:      rd_val = {24'h0, ach_r};
      `FSPC_OFF_ACL:      rd_val = {24'h0, acl_r};
      `FSPC_OFF_WDATA:    rd_val = {24'h0, wdat_r};
      `FSPC_OFF_PROTBYTE: rd_val = {24'h0, protb_r};
      default:            rd_val = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // Plain data registers (pointers, compare, write data, protect byte)
  // ----------------------------------------------------------------
  // Pointer and compare values are only meaningful when software clears
  // the high nibble and matches compare high to the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aph_r   <= `FSPC_RST_BYTE;
      apl_r   <= `FSPC_RST_BYTE;
      ach_r   <= `FSPC_RST_BYTE;
      acl_r   <= `FSPC_RST_BYTE;
      wdat_r  <= `FSPC_RST_BYTE;
      protb_r <= `FSPC_RST_BYTE;
    end else if (wr_en) begin
      if (hit(paddr, `FSPC_OFF_APH))      aph_r   <= pwdata[7:0];
      if (hit(paddr, `FSPC_OFF_APL))      apl_r   <= pwdata[7:0];
      if (hit(paddr, `FSPC_OFF_ACH))      ach_r   <= pwdata[7:0];
      if (hit(paddr, `FSPC_OFF_ACL))      acl_r   <= pwdata[7:0];
      if (hit(paddr, `FSPC_OFF_WDATA))    wdat_r  <= pwdata[7:0];
      if (hit(paddr, `FSPC_OFF_PROTBYTE)) protb_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Protected mode entry: key write, then the mode write right after
  // ----------------------------------------------------------------
  // Any other write to a mapped register after the key cancels it; reads
  // and unmapped writes leave it set. Mode register ignores writes while busy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= 1'b0;
      mode_r   <= 1'b0;
    end else if (wr_en) begin
      unlock_r <= hit(paddr, `FSPC_OFF_PROTCMD) && (pwdata[7:0] == `FSPC_UNLOCK_KEY);
      if (hit(paddr, `FSPC_OFF_MODE) && unlock_r && !busy) begin
        mode_r <= pwdata[0];
      end
    end
  end

  // Protect error: mode write without key; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proterr_r <= 1'b0;
    end else if (wr_en && hit(paddr, `FSPC_OFF_MODE) && !unlock_r) begin
      proterr_r <= 1'b1;
    end else if (wr_en && hit(paddr, `FSPC_OFF_STATUS) && pwdata[`FSPC_ST_PROTERR]) begin
      proterr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Halt after entry: released automatically after the fixed count
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_arm_r <= 1'b0;
      halting_r  <= 1'b0;
      halt_cnt_r <= 12'h000;
    end else begin
      if (wr_en && hit(paddr, `FSPC_OFF_MODE) && unlock_r && !busy && pwdata[0] && !mode_r) begin
        halt_arm_r <= 1'b1;
      end else if (halting_r || !mode_r) begin
        halt_arm_r <= 1'b0;
      end
      if (halt_arm_r && cpu_halt && !halting_r) begin
        halting_r  <= 1'b1;
        halt_cnt_r <= 12'(`FSPC_HALT_CYC - 1);
      end else if (halting_r) begin
        if (halt_cnt_r == 12'h000) begin
          halting_r <= 1'b0;
        end else begin
          halt_cnt_r <= halt_cnt_r - 12'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Command register and sequencer
  // ----------------------------------------------------------------
  // No security gating here: in self programming only the mode bit and
  // the protect byte decide
  assign cmd_start = wr_en && hit(paddr, `FSPC_OFF_CMD) && mode_r && !busy && !halting_r
                     && (pwdata[2:0] != FSPC_CMD_NONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= FSPC_CMD_NONE;
    end else if (wr_en && hit(paddr, `FSPC_OFF_CMD) && !busy) begin
      cmd_r <= fspc_cmd_t'(pwdata[2:0]);  // Zero write needed around mode switches
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FSPC_IDLE;
      ptr_r   <= `FSPC_RST_BYTE;
    end else begin
      unique case (state_r)
        FSPC_IDLE: begin
          if (cmd_start) begin
            if ((pwdata[2:0] == FSPC_CMD_ERASE || pwdata[2:0] == FSPC_CMD_WRITE)
                && (aph_r < protb_r)) begin
              state_r <= FSPC_IDLE;
            end else if (pwdata[2:0] == FSPC_CMD_ERASE) begin
              state_r <= FSPC_ERASE;
              ptr_r   <= 8'h00;
            end else begin
              state_r <= FSPC_READ;
              ptr_r   <= apl_r;
            end
          end
        end
        FSPC_ERASE: begin
          ptr_r <= ptr_r + 8'h01;
          if (ptr_r == 8'hFF) state_r <= FSPC_IDLE;
        end
        FSPC_READ: state_r <= FSPC_CHECK;
        FSPC_CHECK: begin
          if (cmd_r == FSPC_CMD_WRITE || ptr_r == acl_r) begin
            state_r <= FSPC_IDLE;
          end else begin
            ptr_r   <= ptr_r + 8'h01;
            state_r <= FSPC_READ;
          end
        end
      endcase
    end
  end

  // Refused and fail flags; new event wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_r <= 1'b0;
      fail_r    <= 1'b0;
    end else begin
      if (cmd_start && (pwdata[2:0] == FSPC_CMD_ERASE || pwdata[2:0] == FSPC_CMD_WRITE)
          && (aph_r < protb_r)) begin
        refused_r <= 1'b1;
      end else if (wr_en && hit(paddr, `FSPC_OFF_STATUS) && pwdata[`FSPC_ST_REFUSED]) begin
        refused_r <= 1'b0;
      end
      if (state_r == FSPC_CHECK
          && ((cmd_r == FSPC_CMD_BLANK && mrd != `FSPC_BLANK)
           || (cmd_r == FSPC_CMD_WRITE && (mrd & wdat_r) != wdat_r))) begin
        fail_r <= 1'b1;
      end else if (wr_en && hit(paddr, `FSPC_OFF_STATUS) && pwdata[`FSPC_ST_FAIL]) begin
        fail_r <= 1'b0;
      end
    end
  end

  // Array request: erase writes blank, write can only clear bits
  always_comb begin
    mreq.addr  = {aph_r[3:0], ptr_r};
    mreq.we    = 1'b0;
    mreq.wdata = `FSPC_BLANK;
    if (state_r == FSPC_ERASE) begin
      mreq.we = 1'b1;
    end else if (state_r == FSPC_CHECK && cmd_r == FSPC_CMD_WRITE) begin
      mreq.we    = 1'b1;
      mreq.wdata = mrd & wdat_r;
    end
  end

  fspc_flash_array #(
    .DEPTH (4096)
  ) u_array (
    .pclk  (pclk),
    .req   (mreq),
    .rdata (mrd)
  );

  // ----------------------------------------------------------------
  // CPU side controls
  // ----------------------------------------------------------------
  // Stall covers the entry halt and every running command; the CPU clock
  // floor of 1 MHz is the software's concern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_stall <= 1'b0;
      int_block <= 1'b0;
      pin_hold  <= 1'b0;
    end else begin
      cpu_stall <= (halting_r && halt_cnt_r != 12'h000) || (halt_arm_r && cpu_halt)
                   || cmd_start || (busy && !(state_r == FSPC_CHECK && (cmd_r == FSPC_CMD_WRITE
                   || ptr_r == acl_r)) && !(state_r == FSPC_ERASE && ptr_r == 8'hFF));
      int_block <= mode_r;
      pin_hold  <= mode_r;
    end
  end

endmodule : fspc_ctrl

`default_nettype wire

/* File: fspc_cfg.svh */
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FSPC_OFF_MODE      8'h00
`define FSPC_OFF_PROTCMD   8'h04
`define FSPC_OFF_STATUS    8'h08
`define FSPC_OFF_CMD       8'h0C
`define FSPC_OFF_APH       8'h10
`define FSPC_OFF_APL       8'h14
`define FSPC_OFF_ACH       8'h18
`define FSPC_OFF_ACL       8'h1C
`define FSPC_OFF_WDATA     8'h20
`define FSPC_OFF_PROTBYTE  8'h24

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define FSPC_ST_PROTERR    0
`define FSPC_ST_BUSY       1
`define FSPC_ST_REFUSED    2
`define FSPC_ST_FAIL       3
`define FSPC_ST_MODE       4
`define FSPC_UNLOCK_KEY    8'hA5
`define FSPC_BLANK         8'hFF
`define FSPC_RST_BYTE      8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSPC_CLK_NS        4
`define FSPC_HALT_MAX_NS   10000
`define FSPC_HALT_CPU_CLKS 2
`define FSPC_HALT_CYC      ((`FSPC_HALT_MAX_NS / `FSPC_CLK_NS) + `FSPC_HALT_CPU_CLKS)

`endif

/* File: fspc_pkg.sv */
package fspc_pkg;

  // Self programming command codes
  typedef enum logic [2:0] {
    FSPC_CMD_NONE   = 3'h0,
    FSPC_CMD_VERIFY = 3'h2,
    FSPC_CMD_BLANK  = 3'h3,
    FSPC_CMD_ERASE  = 3'h4,
    FSPC_CMD_WRITE  = 3'h5
  } fspc_cmd_t;

  // Sequencer states
  typedef enum logic [1:0] {
    FSPC_IDLE,
    FSPC_READ,
    FSPC_CHECK,
    FSPC_ERASE
  } fspc_state_t;

  // Request to the flash array
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } fspc_mem_req_t;

endpackage : fspc_pkg

/* File: fspc_flash_array.sv */
`timescale 1ns/1ps
`default_nettype none

module fspc_flash_array #(
  parameter int DEPTH = 4096
) (
  input  wire logic                    pclk,
  input  wire fspc_pkg::fspc_mem_req_t req,
  output var  logic [7:0]              rdata
);
  import fspc_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem [DEPTH];

  if (DEPTH != 4096) begin : g_bad_depth
    $error("fspc_flash_array: DEPTH must match the 12-bit address");
  end

  // Synchronous read, one cycle latency; contents are not reset
  always_ff @(posedge pclk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
    rdata <= mem[req.addr];
  end

endmodule : fspc_flash_array

`default_nettype wire

/* File: fspc_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fspc_cfg.svh"

module fspc_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_halt,
  input wire logic        cpu_stall,
  input wire logic        int_block,
  input wire logic        pin_hold
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [11:0] stall_cnt_r;

  // Stall length in a counter: a repetition of 2502 would choke the tools
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stall_cnt_r <= 12'h000;
    else stall_cnt_r <= cpu_stall ? stall_cnt_r + 12'h001 : 12'h000;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wait_state; psel && penable && !pready |=> pready; endproperty
  a_wait_state: assert property (p_wait_state) else $error("no answer after one wait state");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr outside access");
  property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
  property p_halt_bound; stall_cnt_r <= 12'(`FSPC_HALT_CYC); endproperty
  a_halt_bound: assert property (p_halt_bound) else $error("stall too long");
  property p_pins; pin_hold == int_block; endproperty
  a_pins: assert property (p_pins) else $error("pin hold differs from mode");
  property p_flag_bit; pready && !pwrite && paddr == `FSPC_OFF_STATUS |-> prdata[31:5] == 27'h0; endproperty
  a_flag_bit: assert property (p_flag_bit) else $error("status upper bits set");
  property p_mode_cause;
    $rose(int_block) |-> $past(psel && penable && pready && pwrite && paddr == `FSPC_OFF_MODE, 2);
  endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("mode set without write");
  property p_no_cmd_normal; !int_block && !$past(int_block) |-> !cpu_stall; endproperty
  a_no_cmd_normal: assert property (p_no_cmd_normal) else $error("stall in normal mode");
  property p_stall_cause; $rose(cpu_stall) |-> $past(cpu_halt) || $past(pready) || $past(pready, 2); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without cause");
endmodule : fspc_ctrl_chk

bind fspc_ctrl fspc_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .cpu_halt, .cpu_stall, .int_block, .pin_hold);
`default_nettype wire

/* File: fspc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fspc_cpu_model #(
  parameter int SETTLE = 2000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic halt_req,
  input  wire logic cpu_stall,
  output var  logic cpu_halt,
  output var  logic cmd_ok
);
  // ----------------------------------------------------------------
  // Core behaviour (clock is 250 MHz, far above the 1 MHz floor)
  // ----------------------------------------------------------------
  logic        nop_r;
  logic [11:0] settle_r;

  // NOP then HALT after entry; halt drops once the device stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nop_r    <= 1'b0;
      cpu_halt <= 1'b0;
    end else begin
      nop_r <= halt_req;
      if (nop_r) cpu_halt <= 1'b1;
      else if (cpu_stall) cpu_halt <= 1'b0;
    end
  end

  // Crystal clock: 8 us of settling before commands are allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= 12'h000;
      cmd_ok   <= 1'b0;
    end else if (halt_req || nop_r || cpu_halt || cpu_stall) begin
      settle_r <= 12'h000;
      cmd_ok   <= 1'b0;
    end else if (settle_r == 12'(SETTLE)) cmd_ok <= 1'b1;
    else settle_r <= settle_r + 12'h001;
  end
endmodule : fspc_cpu_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fspc_cfg.svh"

module tb;
  import fspc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, halt_req, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq;
  logic        pready, pslverr, cpu_halt, cpu_stall, int_block, pin_hold, cmd_ok;
  int          err_count, n_compared, n;

  fspc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cpu_halt, .cpu_stall, .int_block, .pin_hold);
  fspc_cpu_model u_cpu (.pclk, .presetn, .halt_req, .cpu_stall, .cpu_halt, .cmd_ok);

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Whole run needs about 10k cycles; a hang ends here
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // One APB transfer; idle cycle after it so no signal is driven twice per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk(32'h0, 32'h1, "no pready");
    rq = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Load pointers and start a command, then poll busy; returns status in rq
  task automatic run_cmd(input logic [7:0] aph, apl, acl, input fspc_cmd_t c);
    int k;
    apb(1'b1, `FSPC_OFF_APH, {24'h0, aph});
    apb(1'b1, `FSPC_OFF_ACH, {24'h0, aph});
    apb(1'b1, `FSPC_OFF_APL, {24'h0, apl});
    apb(1'b1, `FSPC_OFF_ACL, {24'h0, acl});
    apb(1'b1, `FSPC_OFF_CMD, {29'h0, c});
    k = 0;
    do begin apb(1'b0, `FSPC_OFF_STATUS, 32'h0); k++; end while (rq[1] !== 1'b0 && k < 300);
    if (k >= 300) chk(32'h0, 32'h1, "command never finished");
  endtask : run_cmd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_normal();
    chk({27'h0, cpu_stall, int_block, pin_hold, pready, pslverr}, 32'h0, "reset outputs");
    apb(1'b0, 8'h30, 32'hFFFF_FFFF);
    chk({31'h0, re}, 32'h1, "unmapped err");
    chk(rq, 32'h0, "unmapped data");
    apb(1'b1, `FSPC_OFF_CMD, {29'h0, FSPC_CMD_ERASE});
    apb(1'b0, `FSPC_OFF_STATUS, 32'h0);
    chk(rq, 32'h0, "command in normal mode");
    apb(1'b1, `FSPC_OFF_MODE, 32'h1);
    apb(1'b0, `FSPC_OFF_STATUS, 32'h0);
    chk(rq, 32'h1, "keyless entry flag");
    apb(1'b1, `FSPC_OFF_STATUS, 32'h1);
    apb(1'b0, `FSPC_OFF_STATUS, 32'h0);
    chk(rq, 32'h0, "flag clear");
    $display("test normal done");
  endtask : t_normal

  task automatic t_enter();
    apb(1'b1, `FSPC_OFF_CMD, 32'h0);
    apb(1'b1, `FSPC_OFF_PROTCMD, {24'h0, `FSPC_UNLOCK_KEY});
    apb(1'b1, `FSPC_OFF_MODE, 32'h1);
    // Mode flops first, the pin and interrupt outputs follow one edge later
    @(posedge pclk);
    chk({30'h0, int_block, pin_hold}, 32'h3, "mode on");
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    n = 0;
    while (cpu_stall !== 1'b1 && n < 10) begin @(posedge pclk); n++; end
    n = 0;
    while (cpu_stall === 1'b1 && n < 3000) begin @(posedge pclk); n++; end
    chk({31'h0, n > 0 && n <= `FSPC_HALT_CYC}, 32'h1, "halt release");
    n = 0;
    while (cmd_ok !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
    chk({31'h0, cmd_ok}, 32'h1, "settling done");
    $display("test enter done");
  endtask : t_enter

  task automatic t_flash();
    run_cmd(8'h02, 8'h00, 8'h00, FSPC_CMD_ERASE);
    run_cmd(8'h02, 8'h00, 8'hFF, FSPC_CMD_BLANK);
    chk(rq, 32'h10, "blank after erase");
    apb(1'b1, `FSPC_OFF_WDATA, 32'h12);
    run_cmd(8'h02, 8'h05, 8'h05, FSPC_CMD_WRITE);
    chk(rq, 32'h10, "write ok");
    run_cmd(8'h02, 8'h00, 8'hFF, FSPC_CMD_BLANK);
    chk(rq, 32'h18, "blank finds data");
    apb(1'b1, `FSPC_OFF_STATUS, 32'h8);
    run_cmd(8'h02, 8'h00, 8'hFF, FSPC_CMD_VERIFY);
    chk(rq, 32'h10, "verify");
    run_cmd(8'h02, 8'h00, 8'h00, FSPC_CMD_ERASE);
    run_cmd(8'h02, 8'h00, 8'hFF, FSPC_CMD_BLANK);
    chk(rq, 32'h10, "blank after second erase");
    apb(1'b1, `FSPC_OFF_PROTBYTE, 32'h3);
    run_cmd(8'h02, 8'h05, 8'h05, FSPC_CMD_WRITE);
    chk(rq, 32'h14, "protected write");
    run_cmd(8'h02, 8'h00, 8'h00, FSPC_CMD_ERASE);
    chk(rq, 32'h14, "protected erase");
    apb(1'b1, `FSPC_OFF_STATUS, 32'h4);
    run_cmd(8'h02, 8'h00, 8'hFF, FSPC_CMD_BLANK);
    chk(rq, 32'h10, "protected data untouched");
    apb(1'b1, `FSPC_OFF_CMD, 32'h0);
    // Leaving the mode is protected too: key, then the mode write at once
    apb(1'b1, `FSPC_OFF_PROTCMD, {24'h0, `FSPC_UNLOCK_KEY});
    apb(1'b1, `FSPC_OFF_MODE, 32'h0);
    @(posedge pclk);
    chk({30'h0, int_block, pin_hold}, 32'h0, "mode off");
    apb(1'b0, `FSPC_OFF_STATUS, 32'h0);
    chk(rq, 32'h0, "status after exit");
    $display("test flash done");
  endtask : t_flash

  // Main sequence; interrupt masking leaves the device on int_block, checked with pin_hold on mode changes
  initial begin
    err_count = 0; n_compared = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; halt_req = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_normal();
    t_enter();
    t_flash();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
